//--- hdl/cdp_cfg.svh
`ifndef CDP_CFG_SVH
`define CDP_CFG_SVH
// register byte offsets
`define CDP_CTRL_OFS     4'h0
`define CDP_STAT_OFS     4'h4
`define CDP_VOL_OFS      4'h8
// field positions
`define CDP_CTRL_MUTE    0
`define CDP_STAT_SSM     3
`define CDP_STAT_RATE    4
`define CDP_STAT_SPREAD  5
`define CDP_STAT_MONO    6
`define CDP_STAT_FAULT   7
`define CDP_CTRL_RST     1'b0
// timing
`define CDP_CLK_HZ       50000000
`define CDP_RATE_LO_KHZ  360
`define CDP_RATE_HI_KHZ  500
`define CDP_PER_LO       (`CDP_CLK_HZ / (`CDP_RATE_LO_KHZ * 1000))
`define CDP_PER_HI       (`CDP_CLK_HZ / (`CDP_RATE_HI_KHZ * 1000))
`define CDP_STARTUP_MS   45
`define CDP_STARTUP_CYC  (`CDP_STARTUP_MS * (`CDP_CLK_HZ / 1000))
`define CDP_RAMP_STEP    6'h3F
`define CDP_SSM_MIN      8'h04
`define CDP_DITHER       8'h04
`define CDP_LFSR_RST     4'h1
`endif

//--- hdl/cdp_pkg.sv
`default_nettype none
package cdp_pkg;
    typedef enum logic [2:0]
    {
        CDP_SHUT  = 3'b000,
        CDP_START = 3'b001,
        CDP_RUN   = 3'b011,
        CDP_FADE  = 3'b010,
        CDP_FAULT = 3'b110
    } cdp_state_t;

    typedef struct packed {
        cdp_state_t  st;
        logic        en1, en2, sc1, sc2, mo1, mo2;
        logic [1:0]  fo1, fo2;
        logic [1:0]  rs1, rs2;
        logic        single_sided_scheme, rate_hi, spread, mono, fault, mute;
        logic [7:0]  vol;
        logic [5:0]  step;
        logic [21:0] dly;
        logic [7:0]  cnt, per;
        logic [3:0]  lfsr;
        logic [1:0]  bp, bn;
        logic        pd, bias;
        logic        bvalid, rvalid;
        logic [1:0]  bresp, rresp;
        logic [31:0] rdata;
    } cdp_regs_t;
endpackage
`default_nettype wire

//--- hdl/cdp_ctrl.sv
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "cdp_cfg.svh"
// How it works
// - rate strap picks 360/500 kHz, spreading
// - scheme pin high or open means single-sided
// - scheme captured at startup, then held
// - double-sided idle: both 50%, in phase
// - positive input: positive above, negative below 50%
// - negative input: positive below, negative above 50%
// - single-sided idle: both outputs under 10%
// - single-sided audio: falling output grounded
// - volume ramps in and out of operation
// - grounded right inputs: left feeds both bridges
// - shutdown ramps all outputs to ground together
// - enable low means shutdown, unbiased, grounded
// - normal operation only after 45ms startup
// - undriven enable reads low, shutdown
// - mute biased and grounded; shutdown unbiased
// - latched fault holds shutdown until enable low
module cdp_ctrl
    import cdp_pkg::*;
#(
    parameter logic [21:0] STARTUP_CYC = 22'(`CDP_STARTUP_CYC)
)
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [3:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [3:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              enable_pin,
    input  wire logic              scheme_select_pin,
    input  wire logic [1:0]        switch_rate_strap,
    input  wire logic              right_in_grounded,
    input  wire logic              ocp_trip,
    input  wire logic              dc_trip,
    input  wire logic signed [7:0] audio_left,
    input  wire logic signed [7:0] audio_right,
    output logic [1:0]             bridge_out_positive,
    output logic [1:0]             bridge_out_negative,
    output logic                   out_pulldown,
    output logic                   analog_bias_en,
    output logic                   fault_flag_n
);

////////////////////////////////////////////////////////////////////
    cdp_regs_t s, n;
    logic [7:0]        base, half;
    logic              tick, drive, wr_go, rd_go, fault_in;
    logic signed [7:0] eff [2];
    logic [7:0]        thr_p [2];
    logic [7:0]        thr_n [2];

    assign base = s.rate_hi ? 8'(`CDP_PER_HI) : 8'(`CDP_PER_LO);
    assign half = {1'b0, s.per[7:1]};
    assign tick = (s.step == `CDP_RAMP_STEP);
    assign drive = (s.st == CDP_RUN || s.st == CDP_FADE) && !s.mute;
    // detectors are merged only after both have been synchronised
    assign fault_in = s.fo2[0] || s.fo2[1];

////////////////////////////////////////////////////////////////////
    // per bridge: scale by volume, then pick duty thresholds
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_ch
        logic signed [7:0]  aud;
        logic signed [16:0] prod;
        logic [7:0]         mag, delta;
        logic [15:0]        span;
        // mono routes the left sample to the right bridge too
        assign aud = (ch == 1 && !s.mono) ? audio_right : audio_left;
        assign prod = aud * $signed({1'b0, s.vol});
        // clamp keeps delta at most half, so no underflow below
        assign eff[ch] = (prod[15:8] == 8'h80) ? 8'h81 : prod[15:8];
        assign mag = eff[ch][7] ? 8'(-eff[ch]) : eff[ch];
        assign span = mag * half;
        // any non-zero scaled sample moves the duty by at least one cycle
        assign delta = span[14:7] | {7'h00, (mag != 8'h00)};
        always_comb
        begin
            if (!s.single_sided_scheme)
            begin
                // both sit at half when idle, so they stay in phase
                thr_p[ch] = eff[ch][7] ? half - delta : half + delta;
                thr_n[ch] = eff[ch][7] ? half + delta : half - delta;
            end
            else if (eff[ch] == 8'h00)
            begin
                thr_p[ch] = `CDP_SSM_MIN;
                thr_n[ch] = `CDP_SSM_MIN;
            end
            else if (!eff[ch][7])
            begin
                thr_p[ch] = `CDP_SSM_MIN + delta;
                thr_n[ch] = 8'h00;
            end
            else
            begin
                thr_p[ch] = 8'h00;
                thr_n[ch] = `CDP_SSM_MIN + delta;
            end
        end
    end

////////////////////////////////////////////////////////////////////
    // bus handshakes: one write and one read outstanding
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s.bvalid;
    assign rd_go = s_axi_arvalid && !s.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;

    // next state of everything
    always_comb
    begin
        n = s;
        // pins cross in through two flops each
        n.en1 = enable_pin;
        n.en2 = s.en1;
        n.sc1 = scheme_select_pin;
        n.sc2 = s.sc1;
        n.mo1 = right_in_grounded;
        n.mo2 = s.mo1;
        n.rs1 = switch_rate_strap;
        n.rs2 = s.rs1;
        n.fo1 = {dc_trip, ocp_trip};
        n.fo2 = s.fo1;
        n.step = s.step + 6'h01;
        // carrier counter, period re-chosen at each wrap
        if (s.cnt >= s.per - 8'h01)
        begin
            n.cnt = 8'h00;
            n.lfsr = {s.lfsr[2:0], s.lfsr[3] ^ s.lfsr[2]};
            n.per = s.spread ? base - `CDP_DITHER + {5'h00, s.lfsr[2:0]}
                             : base;
        end
        else
        begin
            n.cnt = s.cnt + 8'h01;
        end
        case (s.st)
            CDP_SHUT:
            begin
                n.fault = 1'b0;
                n.vol = 8'h00;
                n.dly = 22'h000000;
                if (s.en2)
                begin
                    // straps are sampled only here, at each startup
                    n.single_sided_scheme = s.sc2;
                    n.rate_hi = s.rs2[1];
                    n.spread = s.rs2[0];
                    n.mono = s.mo2;
                    n.st = CDP_START;
                end
            end
            CDP_START:
            begin
                if (!s.en2)
                    n.st = CDP_SHUT;
                else if (fault_in)
                begin
                    n.fault = 1'b1;
                    n.st = CDP_FAULT;
                end
                else if (s.dly == STARTUP_CYC - 22'h000001)
                    n.st = CDP_RUN;
                else
                    n.dly = s.dly + 22'h000001;
            end
            CDP_RUN:
            begin
                if (fault_in)
                begin
                    n.fault = 1'b1;
                    n.vol = 8'h00;
                    n.st = CDP_FAULT;
                end
                else if (!s.en2)
                    n.st = CDP_FADE;
                else if (tick && s.vol != 8'hFF)
                    n.vol = s.vol + 8'h01;
            end
            CDP_FADE:
            begin
                // re-enable here still ends in a full restart
                if (fault_in)
                begin
                    n.fault = 1'b1;
                    n.vol = 8'h00;
                    n.st = CDP_FAULT;
                end
                else if (s.vol == 8'h00)
                    n.st = CDP_SHUT;
                else if (tick)
                    n.vol = s.vol - 8'h01;
            end
            CDP_FAULT:
            begin
                if (!s.en2)
                    n.st = CDP_SHUT;
            end
            default:
                n.st = CDP_SHUT;
        endcase
        // outputs: bias stays on in mute, off in shutdown
        n.bias = (s.st != CDP_SHUT) && (s.st != CDP_FAULT);
        n.pd = !drive;
        for (int c = 0; c < 2; c++)
        begin
            n.bp[c] = drive && (s.cnt < thr_p[c]);
            n.bn[c] = drive && (s.cnt < thr_n[c]);
        end
        // register writes
        if (s.bvalid && s_axi_bready)
            n.bvalid = 1'b0;
        if (wr_go)
        begin
            n.bvalid = 1'b1;
            n.bresp = 2'b10;
            if ({s_axi_awaddr[3:2], 2'b00} == `CDP_CTRL_OFS)
            begin
                n.bresp = 2'b00;
                if (s_axi_wstrb[0])
                    n.mute = s_axi_wdata[`CDP_CTRL_MUTE];
            end
        end
        // register reads
        if (s.rvalid && s_axi_rready)
            n.rvalid = 1'b0;
        if (rd_go)
        begin
            n.rvalid = 1'b1;
            n.rresp = 2'b00;
            n.rdata = 32'h00000000;
            case ({s_axi_araddr[3:2], 2'b00})
                `CDP_CTRL_OFS:
                    n.rdata[`CDP_CTRL_MUTE] = s.mute;
                `CDP_STAT_OFS:
                begin
                    n.rdata[2:0] = s.st;
                    n.rdata[`CDP_STAT_SSM] = s.single_sided_scheme;
                    n.rdata[`CDP_STAT_RATE] = s.rate_hi;
                    n.rdata[`CDP_STAT_SPREAD] = s.spread;
                    n.rdata[`CDP_STAT_MONO] = s.mono;
                    n.rdata[`CDP_STAT_FAULT] = s.fault;
                end
                `CDP_VOL_OFS:
                    n.rdata[7:0] = s.vol;
                default:
                    n.rresp = 2'b10;
            endcase
        end
    end

////////////////////////////////////////////////////////////////////
    // all state in one register, synchronous reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.st <= CDP_SHUT;
            s.mute <= `CDP_CTRL_RST;
            s.per <= 8'(`CDP_PER_LO);
            s.lfsr <= `CDP_LFSR_RST;
            s.pd <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    assign bridge_out_positive = s.bp;
    assign bridge_out_negative = s.bn;
    assign out_pulldown = s.pd;
    assign analog_bias_en = s.bias;
    assign fault_flag_n = !s.fault;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = s.rdata;

////////////////////////////////////////////////////////////////////
    // checks on the block's own behaviour
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_rate_decode: assert property (
        s.st == CDP_SHUT && s.en2 |=> s.rate_hi == $past(s.rs2[1])
            && s.spread == $past(s.rs2[0]))
        else $error("rate strap decode wrong");
    a_scheme_pick: assert property (
        s.st == CDP_SHUT && s.en2 |=> s.single_sided_scheme == $past(s.sc2))
        else $error("scheme pick wrong");
    a_scheme_hold: assert property (
        s.st != CDP_SHUT && $past(s.st) != CDP_SHUT |-> $stable(s.single_sided_scheme))
        else $error("scheme changed in operation");
    a_dsm_idle: assert property (
        !s.single_sided_scheme && eff[0] == 8'h00 |-> thr_p[0] == half && thr_n[0] == half)
        else $error("double-sided idle not 50%");
    a_dsm_pos: assert property (
        !s.single_sided_scheme && !eff[0][7] && eff[0] != 8'h00
            |-> thr_p[0] > half && thr_n[0] < half)
        else $error("positive duty wrong");
    a_dsm_neg: assert property (
        !s.single_sided_scheme && eff[0][7] |-> thr_p[0] < half && thr_n[0] > half)
        else $error("negative duty wrong");
    a_ssm_idle: assert property (
        s.single_sided_scheme && eff[0] == 8'h00 |-> thr_p[0] == `CDP_SSM_MIN
            && thr_n[0] == `CDP_SSM_MIN && {`CDP_SSM_MIN, 4'h0} < {s.per, 4'h0} / 10)
        else $error("single-sided idle too wide");
    a_ssm_rail: assert property (
        s.single_sided_scheme && eff[0] != 8'h00 |-> (eff[0][7] ? thr_p[0] : thr_n[0]) == 8'h00)
        else $error("falling output not grounded");
    a_fade_in: assert property (
        s.st == CDP_RUN && s.en2 && !fault_in && tick && s.vol != 8'hFF
            |=> s.vol == $past(s.vol) + 8'h01)
        else $error("volume not ramping up");
    a_mono_route: assert property (
        s.mono |-> eff[1] == eff[0])
        else $error("mono routing wrong");
    a_fade_out: assert property (
        s.st == CDP_FADE && !fault_in && tick && s.vol != 8'h00
            |=> s.vol == $past(s.vol) - 8'h01)
        else $error("volume not ramping down");
    a_shut_ground: assert property (
        $past(s.st) == CDP_SHUT |-> s.pd && !s.bias && s.bp == 2'b00 && s.bn == 2'b00)
        else $error("shutdown outputs not grounded");
    a_start_wait: assert property (
        $rose(s.st == CDP_RUN) |-> $past(s.dly) == STARTUP_CYC - 22'h000001)
        else $error("startup delay short");
    a_mute_bias: assert property (
        $past(s.st) == CDP_RUN && $past(s.mute) |-> s.bias && s.pd && s.bp == 2'b00)
        else $error("mute not biased and grounded");
    a_fault_hold: assert property (
        s.st == CDP_FAULT && s.en2 |=> s.st == CDP_FAULT && !fault_flag_n)
        else $error("fault released early");
    a_dither_span: assert property (
        s.cnt == 8'h00 && $past(s.st) == CDP_RUN |-> s.spread
            ? (s.per >= base - `CDP_DITHER && s.per < base + `CDP_DITHER)
            : s.per == base)
        else $error("period out of range");

    c_run: cover property (s.st == CDP_START ##1 s.st == CDP_RUN);
    c_fault: cover property (s.st == CDP_RUN ##1 s.st == CDP_FAULT);
    c_fade_done: cover property (s.st == CDP_FADE ##1 s.st == CDP_SHUT);
    c_write: cover property (wr_go && s_axi_wdata[0]);

endmodule // cdp_ctrl
`default_nettype wire

//--- tb/cdp_host.sv
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////
// host side: owns the enable pin and honours the settle time
module cdp_host #(
    parameter int SETTLE = 16
)
(
    input  wire logic aclk,
    input  wire logic want_on,
    output logic      enable_pin
);
    logic oe = 1'h0;
    logic drv = 1'h0;
    int   low_n = 0;
    // floating pin reads low, so power-up lands in shutdown
    assign enable_pin = oe ? drv : 1'h0;
    // enable rises only after a full settle period low
    always @(posedge aclk)
    begin
        low_n <= drv ? 0 : low_n + 1;
        if (!want_on)
            drv <= 1'h0;
        else if (low_n >= SETTLE)
        begin
            oe  <= 1'h1;
            drv <= 1'h1;
        end
    end
endmodule // cdp_host
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "cdp_cfg.svh"
module tb;
    logic              aclk = 1'h0;
    logic              aresetn = 1'h0;
    logic [3:0]        awaddr = 4'h0;
    logic [3:0]        araddr = 4'h0;
    logic [31:0]       wdata = 32'h0;
    logic              awvalid = 1'h0;
    logic              wvalid = 1'h0;
    logic              bready = 1'h0;
    logic              arvalid = 1'h0;
    logic              rready = 1'h0;
    logic              want_on = 1'h0;
    logic              sch = 1'h1;
    logic              mono = 1'h0;
    logic [1:0]        trip = 2'h0;
    logic [1:0]        rate = 2'h0;
    logic signed [7:0] al = 8'sh00;
    logic signed [7:0] ar = 8'sh00;
    logic              awready, wready, bvalid, arready, rvalid, pd, bias, fn, en;
    logic [1:0]        bresp, rresp, bp, bn;
    logic [31:0]       rdata;
    int                n_fail = 0;
    int                comparisons = 0;
    int                cycles = 0;
    //////////////////////////////
    // 50 MHz clock
    always #10 aclk = ~aclk;
    cdp_host #(.SETTLE(16)) host (.aclk(aclk), .want_on(want_on), .enable_pin(en));
    // short startup keeps the run brief
    cdp_ctrl #(.STARTUP_CYC(22'h14)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .enable_pin(en),
        .scheme_select_pin(sch), .switch_rate_strap(rate), .right_in_grounded(mono),
        .ocp_trip(trip[0]), .dc_trip(trip[1]), .audio_left(al), .audio_right(ar),
        .bridge_out_positive(bp), .bridge_out_negative(bn), .out_pulldown(pd),
        .analog_bias_en(bias), .fault_flag_n(fn));
    //////////////////////////////
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'h1)
        begin
            n_fail++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // bus tasks: entered just after a rising edge, leave one idle edge behind
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        do @(posedge aclk); while (awready !== 1'h1);
        awvalid <= 1'h0;
        wvalid  <= 1'h0;
        do @(posedge aclk); while (bvalid !== 1'h1);
        r = bresp;
        bready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        @(posedge aclk);
    endtask
    // one carrier period from a rising edge of the positive output
    task automatic meas(input int ch, output int hp, output int hn, output int mis,
                        output int per);
        int k;
        hn = 0;
        mis = 0;
        for (k = 0; k < 300 && bp[ch] !== 1'h0; k++)
            @(posedge aclk);
        for (k = 0; k < 300 && bp[ch] !== 1'h1; k++)
            @(posedge aclk);
        for (hp = 0; hp < 300 && bp[ch] === 1'h1; hp++)
        begin
            hn += int'(bn[ch] === 1'h1);
            mis += int'(bn[ch] !== bp[ch]);
            @(posedge aclk);
        end
        for (per = hp; per < 300 && bp[ch] !== 1'h1; per++)
        begin
            hn += int'(bn[ch] === 1'h1);
            mis += int'(bn[ch] !== bp[ch]);
            @(posedge aclk);
        end
    endtask
    task automatic start(input logic s, input logic [1:0] q, input logic m);
        int n;
        sch     <= s;
        rate    <= q;
        mono    <= m;
        want_on <= 1'h1;
        do @(posedge aclk); while (en !== 1'h1);
        for (n = 0; n < 100 && pd !== 1'h0; n++)
            @(posedge aclk);
        chk(n >= 20 && n <= 26 && bias === 1'h1, "startup delay");
    endtask
    task automatic stop;
        logic [31:0] v;
        logic [1:0]  r;
        int          n;
        rd(4'h8, v, r);
        want_on <= 1'h0;
        for (n = 0; n < 20000 && pd !== 1'h1; n++)
            @(posedge aclk);
        chk(n >= (int'(v[7:0]) - 1) * 64 && n <= int'(v[7:0]) * 64 + 200, "fade");
        chk(bp === 2'h0 && bn === 2'h0 && bias === 1'h0, "shutdown pins");
    endtask
    //////////////////////////////
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0]  r;
        chk(en === 1'h0 && pd === 1'h1 && bias === 1'h0 && fn === 1'h1, "idle pins");
        chk(bp === 2'h0 && bn === 2'h0, "idle bridges");
        rd(4'hC, d, r);
        chk(r === 2'h2, "unmapped read");
        wr(4'h4, 32'hFF, r);
        chk(r === 2'h2, "read-only write");
        rd(4'h4, d, r);
        chk(d[2:0] === 3'h0 && d[7] === 1'h0 && r === 2'h0, "idle status");
        $display("t_reset done");
    endtask
    task automatic t_dsm;
        logic [31:0] d;
        logic [1:0]  r;
        int          hp, hn, mis, per;
        start(1'h0, 2'h0, 1'h1);
        rd(4'h8, d, r);
        chk(d[7:0] <= 8'h02, "volume starts low");
        rd(4'h4, d, r);
        chk(d[6:0] === 7'h43, "dsm status");
        meas(0, hp, hn, mis, per);
        chk(per == `CDP_PER_LO && hp == per / 2 && hn == hp && mis == 0, "dsm idle");
        cyc(3200);
        rd(4'h8, d, r);
        chk(d[7:0] >= 8'h32 && d[7:0] <= 8'h40, "volume ramp");
        al <= 8'sh64;
        ar <= -8'sh64;
        cyc(2);
        meas(0, hp, hn, mis, per);
        chk(hp > per / 2 && hn < per / 2, "positive drive");
        meas(1, hp, hn, mis, per);
        chk(hp > per / 2 && hn < per / 2, "mono drive");
        al <= -8'sh64;
        cyc(2);
        meas(0, hp, hn, mis, per);
        chk(hp < per / 2 && hn > per / 2, "negative drive");
        wr(4'h0, 32'h1, r);
        cyc(3);
        chk(r === 2'h0 && bp === 2'h0 && bn === 2'h0 && pd === 1'h1 && bias === 1'h1, "mute");
        rd(4'h0, d, r);
        chk(d === 32'h1 && r === 2'h0, "mute readback");
        wr(4'h0, 32'h0, r);
        al <= 8'sh00;
        ar <= 8'sh00;
        stop;
        $display("t_dsm done");
    endtask
    task automatic t_rates;
        logic [31:0] d;
        logic [1:0]  r;
        int          hp, hn, mis, per, base, odd;
        for (int q = 0; q < 4; q++)
        begin
            start(1'h0, 2'(q), 1'h0);
            rd(4'h4, d, r);
            chk(d[5:4] === {q[0], q[1]}, "rate status");
            base = q[1] ? `CDP_PER_HI : `CDP_PER_LO;
            odd = 0;
            repeat (6)
            begin
                meas(0, hp, hn, mis, per);
                odd += int'(per != base);
                chk(q[0] ? (per >= base - 4 && per < base + 4) : per == base, "period");
            end
            chk(q[0] ? odd > 0 : odd == 0, "dither");
            stop;
        end
        $display("t_rates done");
    endtask
    task automatic t_ssm;
        logic [31:0] d;
        logic [1:0]  r;
        int          hp, hn, mis, per;
        start(1'h1, 2'h2, 1'h0);
        rd(4'h4, d, r);
        chk(d[6:0] === 7'h1B, "ssm status");
        meas(0, hp, hn, mis, per);
        chk(hp == `CDP_SSM_MIN && hn == hp && hp * 10 < per, "ssm idle");
        sch <= 1'h0;
        cyc(8);
        rd(4'h4, d, r);
        chk(d[3] === 1'h1, "scheme held");
        cyc(3000);
        al <= 8'sh64;
        cyc(2);
        meas(0, hp, hn, mis, per);
        chk(hp > `CDP_SSM_MIN && hn == 0, "one side switches");
        al <= 8'sh00;
        stop;
        $display("t_ssm done");
    endtask
    task automatic t_fault;
        logic [31:0] d;
        logic [1:0]  r;
        for (int k = 0; k < 2; k++)
        begin
            start(1'h0, 2'h0, 1'h0);
            trip <= 2'h1 << k;
            cyc(4);
            trip <= 2'h0;
            cyc(6);
            rd(4'h4, d, r);
            chk(fn === 1'h0 && pd === 1'h1 && bias === 1'h0 && d[7:0] === 8'h86, "latch");
            want_on <= 1'h0;
            cyc(6);
            chk(fn === 1'h1, "latch cleared");
        end
        $display("t_fault done");
    endtask
    //////////////////////////////
    task automatic end_of_test;
        $display("compared %0d, failed %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // hang guard, well above the expected run length
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_fail++;
            end_of_test;
        end
    end
    // main sequence: five-cycle reset, then the scenarios
    initial
    begin
        cyc(5);
        aresetn <= 1'h1;
        cyc(1);
        t_reset;
        t_dsm;
        t_rates;
        t_ssm;
        t_fault;
        end_of_test;
    end
endmodule // tb
`default_nettype wire
